// ===== core/sric_host.sv
// Module: host controller driving the request stream and register port
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sric_host
  import sric_pkg::*;
#(
  parameter int unsigned ALIGN_BITS = RQ_ALIGN_DEF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Register port master toward the device
  output logic [LITE_AW-1:0] o_csr_awaddr,
  output logic [PROT_W-1:0] o_csr_awprot,
  output logic o_csr_awvalid,
  input wire logic i_csr_awready,
  output logic [31:0] o_csr_wdata,
  output logic [STRB_W-1:0] o_csr_wstrb,
  output logic o_csr_wvalid,
  input wire logic i_csr_wready,
  input wire logic [RESP_W-1:0] i_csr_bresp,
  input wire logic i_csr_bvalid,
  output logic o_csr_bready,
  output logic [LITE_AW-1:0] o_csr_araddr,
  output logic [PROT_W-1:0] o_csr_arprot,
  output logic o_csr_arvalid,
  input wire logic i_csr_arready,
  input wire logic [31:0] i_csr_rdata,
  input wire logic [RESP_W-1:0] i_csr_rresp,
  input wire logic i_csr_rvalid,
  output logic o_csr_rready,
  // Request stream master
  output logic [TDATA_W-1:0] o_rqst_tdata,
  output logic [TUSER_W-1:0] o_rqst_tuser,
  output logic o_rqst_tlast,
  output logic [TID_W-1:0] o_rqst_tid,
  output logic o_rqst_tvalid,
  input wire logic i_rqst_tready
);
  sric_cmd_if cmd ();

  // APB state
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic acc_wr;
  // Register-port staging
  logic [LITE_AW-1:0] laddr_q, laddr_d;
  logic [31:0] lwdata_q, lwdata_d;
  logic lwrite_q, lwrite_d;
  logic [STRB_W-1:0] lstrb_q, lstrb_d;
  logic lstart_q, lstart_d, ldone_q, ldone_d;
  logic [PROT_W-1:0] prot_q;
  // Request staging
  logic [31:0] raddr_q, raddr_d;
  logic [31:0] dw_q [DATA_WORDS];
  logic [31:0] dw_d [DATA_WORDS];
  logic [31:0] mw_q [MASK_WORDS];
  logic [31:0] mw_d [MASK_WORDS];
  // Stream state
  logic tvalid_q, tvalid_d, tlast_q, tlast_d;
  logic [TID_W-1:0] tid_q, tid_d, ntid_q, ntid_d, ltid_q, ltid_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [TDATA_W-1:0] tdata_q, tdata_d;
  logic [TUSER_W-1:0] tuser_q, tuser_d;
  logic [31:0] amask;

  function automatic logic is_data(input logic [APB_AW-1:0] a);
    return (a >= OFS_RQ_DATA) && (a < OFS_RQ_MASK) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mask(input logic [APB_AW-1:0] a);
    return (a >= OFS_RQ_MASK) && (a < OFS_RQ_MASK + 12'(4 * MASK_WORDS))
      && (a[1:0] == 2'b00);
  endfunction

  function automatic logic hit(input logic [APB_AW-1:0] a);
    return is_data(a) || is_mask(a) || (a inside {OFS_LITE_ADDR, OFS_LITE_WDATA,
      OFS_LITE_CTRL, OFS_LITE_STAT, OFS_LITE_RDATA, OFS_RQ_ADDR, OFS_RQ_CTRL,
      OFS_RQ_STAT});
  endfunction

  function automatic logic [31:0] rd_word(input logic [APB_AW-1:0] a);
    logic [31:0] v;
    v = RST_WORD;
    if (is_data(a)) begin
      v = dw_q[5'((a - OFS_RQ_DATA) >> 2)];
    end else if (is_mask(a)) begin
      v = mw_q[2'((a - OFS_RQ_MASK) >> 2)];
    end else begin
      case (a)
        OFS_LITE_ADDR: v[LITE_AW-1:0] = laddr_q;
        OFS_LITE_WDATA: v = lwdata_q;
        OFS_LITE_CTRL: begin
          v[LCTL_WRITE_BIT] = lwrite_q;
          v[LCTL_STRB_LSB +: STRB_W] = lstrb_q;
        end
        OFS_LITE_STAT: begin
          v[LSTAT_BUSY_BIT] = cmd.busy | lstart_q | cmd.done;
          v[LSTAT_DONE_BIT] = ldone_q;
          v[LSTAT_RESP_LSB +: RESP_W] = cmd.resp;
        end
        OFS_LITE_RDATA: v = cmd.rdata;
        OFS_RQ_ADDR: v = raddr_q;
        OFS_RQ_CTRL: begin
          v[RCTL_TYPE_BIT] = tuser_q[TU_TYPE_BIT];
          v[RCTL_EXT_LSB +: EXT_W] = tuser_q[TU_EXT_LSB +: EXT_W];
        end
        OFS_RQ_STAT: begin
          v[RSTAT_PEND_BIT] = tvalid_q;
          v[RSTAT_TID_LSB +: TID_W] = ltid_q;
          v[RSTAT_CNT_LSB +: CNT_W] = cnt_q;
        end
        default: v = RST_WORD;
      endcase
    end
    return v;
  endfunction

  // Slave answers in the first cycle of the access phase
  always_comb begin
    pready_d = i_psel && !i_penable;
    pslverr_d = pslverr_q;
    prdata_d = prdata_q;
    if (i_psel && !i_penable) begin
      pslverr_d = !hit(i_paddr);
      prdata_d = i_pwrite ? RST_WORD : rd_word(i_paddr);
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RST_WORD;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign acc_wr = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;

  // Register-port commands; a launch while busy is dropped
  always_comb begin
    laddr_d = laddr_q;
    lwdata_d = lwdata_q;
    lwrite_d = lwrite_q;
    lstrb_d = lstrb_q;
    lstart_d = 1'b0;
    ldone_d = ldone_q;
    if (acc_wr && i_paddr == OFS_LITE_ADDR) laddr_d = i_pwdata[LITE_AW-1:0];
    if (acc_wr && i_paddr == OFS_LITE_WDATA) lwdata_d = i_pwdata;
    if (acc_wr && i_paddr == OFS_LITE_CTRL && !cmd.busy && !lstart_q && !cmd.done) begin
      lwrite_d = i_pwdata[LCTL_WRITE_BIT];
      lstrb_d = i_pwdata[LCTL_STRB_LSB +: STRB_W];
      lstart_d = 1'b1;
      ldone_d = 1'b0;
    end
    if (cmd.done) ldone_d = 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      laddr_q <= '0;
      lwdata_q <= RST_WORD;
      lwrite_q <= 1'b0;
      lstrb_q <= '0;
      lstart_q <= 1'b0;
      ldone_q <= 1'b0;
      prot_q <= PROT_VALUE;
    end else begin
      laddr_q <= laddr_d;
      lwdata_q <= lwdata_d;
      lwrite_q <= lwrite_d;
      lstrb_q <= lstrb_d;
      lstart_q <= lstart_d;
      ldone_q <= ldone_d;
      prot_q <= PROT_VALUE;
    end
  end

  assign cmd.start = lstart_q;
  assign cmd.write = lwrite_q;
  assign cmd.addr = laddr_q;
  assign cmd.wdata = lwdata_q;
  assign cmd.strb = lstrb_q;

  // Request staging words; editing them never disturbs a pending beat
  always_comb begin
    raddr_d = raddr_q;
    dw_d = dw_q;
    mw_d = mw_q;
    if (acc_wr && i_paddr == OFS_RQ_ADDR) raddr_d = i_pwdata;
    if (acc_wr && is_data(i_paddr)) dw_d[5'((i_paddr - OFS_RQ_DATA) >> 2)] = i_pwdata;
    if (acc_wr && is_mask(i_paddr)) mw_d[2'((i_paddr - OFS_RQ_MASK) >> 2)] = i_pwdata;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      raddr_q <= RST_WORD;
      for (int i = 0; i < DATA_WORDS; i++) dw_q[i] <= RST_WORD;
      for (int i = 0; i < MASK_WORDS; i++) mw_q[i] <= RST_WORD;
    end else begin
      raddr_q <= raddr_d;
      dw_q <= dw_d;
      mw_q <= mw_d;
    end
  end

  // low bits forced to the request size boundary
  assign amask = ~((32'h1 << ALIGN_BITS) - 32'h1);

  // Stream master; a new launch is refused while a beat is pending
  always_comb begin
    tvalid_d = tvalid_q;
    tlast_d = tlast_q;
    tid_d = tid_q;
    ntid_d = ntid_q;
    ltid_d = ltid_q;
    cnt_d = cnt_q;
    tdata_d = tdata_q;
    tuser_d = tuser_q;
    if (tvalid_q && i_rqst_tready) begin
      tvalid_d = 1'b0;
      tlast_d = 1'b0;
      ltid_d = tid_q;
      cnt_d = cnt_q + 16'h0001;
    end
    if (acc_wr && i_paddr == OFS_RQ_CTRL && !tvalid_q) begin
      for (int i = 0; i < 16; i++) tdata_d[i*32 +: 32] = dw_q[i];
      tuser_d = '0;
      tuser_d[TU_DHI_LSB +: DHI_W] = {dw_q[19], dw_q[18], dw_q[17], dw_q[16]};
      tuser_d[TU_MASK_LSB +: MASK_W] = {mw_q[2][15:0], mw_q[1], mw_q[0]};
      tuser_d[TU_TYPE_BIT] = i_pwdata[RCTL_TYPE_BIT];
      tuser_d[TU_EXT_LSB +: EXT_W] = i_pwdata[RCTL_EXT_LSB +: EXT_W];
      tuser_d[TU_ADDR_LSB +: 32] = raddr_q & amask;
      tid_d = ntid_q;
      ntid_d = ntid_q + 8'h01;
      tvalid_d = 1'b1;
      tlast_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tvalid_q <= 1'b0;
      tlast_q <= 1'b0;
      tid_q <= RST_TID;
      ntid_q <= RST_TID;
      ltid_q <= RST_TID;
      cnt_q <= '0;
      tdata_q <= '0;
      tuser_q <= '0;
    end else begin
      tvalid_q <= tvalid_d;
      tlast_q <= tlast_d;
      tid_q <= tid_d;
      ntid_q <= ntid_d;
      ltid_q <= ltid_d;
      cnt_q <= cnt_d;
      tdata_q <= tdata_d;
      tuser_q <= tuser_d;
    end
  end

  sric_lite_master i_sric_lite_master (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .cmd(cmd.eng),
    .o_awaddr(o_csr_awaddr),
    .o_awvalid(o_csr_awvalid),
    .i_awready(i_csr_awready),
    .o_wdata(o_csr_wdata),
    .o_wstrb(o_csr_wstrb),
    .o_wvalid(o_csr_wvalid),
    .i_wready(i_csr_wready),
    .i_bresp(i_csr_bresp),
    .i_bvalid(i_csr_bvalid),
    .o_bready(o_csr_bready),
    .o_araddr(o_csr_araddr),
    .o_arvalid(o_csr_arvalid),
    .i_arready(i_csr_arready),
    .i_rdata(i_csr_rdata),
    .i_rresp(i_csr_rresp),
    .i_rvalid(i_csr_rvalid),
    .o_rready(o_csr_rready)
  );

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_csr_awprot = prot_q;
  assign o_csr_arprot = prot_q;
  assign o_rqst_tdata = tdata_q;
  assign o_rqst_tuser = tuser_q;
  assign o_rqst_tlast = tlast_q;
  assign o_rqst_tid = tid_q;
  assign o_rqst_tvalid = tvalid_q;
endmodule // sric_host
`default_nettype wire

// ===== core/sric_pkg.sv
// Package: constants and types for the stream request intake host controller
package sric_pkg;
  // Register offsets on the APB side
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] OFS_LITE_ADDR = 12'h000;
  localparam logic [11:0] OFS_LITE_WDATA = 12'h004;
  localparam logic [11:0] OFS_LITE_CTRL = 12'h008;
  localparam logic [11:0] OFS_LITE_STAT = 12'h00c;
  localparam logic [11:0] OFS_LITE_RDATA = 12'h010;
  localparam logic [11:0] OFS_RQ_ADDR = 12'h014;
  localparam logic [11:0] OFS_RQ_CTRL = 12'h018;
  localparam logic [11:0] OFS_RQ_STAT = 12'h01c;
  localparam logic [11:0] OFS_RQ_DATA = 12'h040;
  localparam logic [11:0] OFS_RQ_MASK = 12'h090;
  localparam int unsigned DATA_WORDS = 20;
  localparam int unsigned MASK_WORDS = 3;
  // Field positions
  localparam int unsigned LCTL_WRITE_BIT = 0;
  localparam int unsigned LCTL_STRB_LSB = 4;
  localparam int unsigned LSTAT_BUSY_BIT = 0;
  localparam int unsigned LSTAT_DONE_BIT = 1;
  localparam int unsigned LSTAT_RESP_LSB = 2;
  localparam int unsigned RCTL_TYPE_BIT = 0;
  localparam int unsigned RCTL_EXT_LSB = 1;
  localparam int unsigned RSTAT_PEND_BIT = 0;
  localparam int unsigned RSTAT_TID_LSB = 8;
  localparam int unsigned RSTAT_CNT_LSB = 16;
  // Sideband layout
  localparam int unsigned TU_DHI_LSB = 128;
  localparam int unsigned TU_MASK_LSB = 40;
  localparam int unsigned TU_TYPE_BIT = 35;
  localparam int unsigned TU_EXT_LSB = 32;
  localparam int unsigned TU_ADDR_LSB = 0;
  // Widths
  localparam int unsigned LITE_AW = 7;
  localparam int unsigned PROT_W = 3;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned RESP_W = 2;
  localparam int unsigned EXT_W = 3;
  localparam int unsigned TID_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned TDATA_W = 512;
  localparam int unsigned TUSER_W = 256;
  localparam int unsigned DHI_W = 128;
  localparam int unsigned MASK_W = 80;
  // Reset values and defaults
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [PROT_W-1:0] PROT_VALUE = 3'h0;
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [TID_W-1:0] RST_TID = 8'h00;
  localparam int unsigned RQ_ALIGN_DEF = 6;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_WR = 3'b001,
    ENG_BR = 3'b010,
    ENG_AR = 3'b011,
    ENG_RD = 3'b100
  } sric_eng_state_t;
endpackage

// ===== core/sric_cmd_if.sv
// Interface: command and result between the host top and its register engine
`timescale 1ns/10ps
`default_nettype none
interface sric_cmd_if;
  import sric_pkg::*;
  logic start;
  logic write;
  logic [LITE_AW-1:0] addr;
  logic [31:0] wdata;
  logic [STRB_W-1:0] strb;
  logic busy;
  logic done;
  logic [RESP_W-1:0] resp;
  logic [31:0] rdata;
  modport ctl (output start, write, addr, wdata, strb, input busy, done, resp, rdata);
  modport eng (input start, write, addr, wdata, strb, output busy, done, resp, rdata);
endinterface
`default_nettype wire

// ===== core/sric_lite_master.sv
// Module: single-access register-port master toward the device
`timescale 1ns/10ps
`default_nettype none
module sric_lite_master
  import sric_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Command side
  sric_cmd_if.eng cmd,
  // Register port master
  output logic [LITE_AW-1:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [STRB_W-1:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [RESP_W-1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic [LITE_AW-1:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [RESP_W-1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready
);
  sric_eng_state_t st_q, st_d;
  logic awv_q, awv_d, wv_q, wv_d, br_q, br_d, arv_q, arv_d, rr_q, rr_d;
  logic done_q, done_d;
  logic [LITE_AW-1:0] awa_q, awa_d, ara_q, ara_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [STRB_W-1:0] ws_q, ws_d;
  logic [RESP_W-1:0] resp_q, resp_d;

  always_comb begin
    st_d = st_q;
    awv_d = awv_q;
    wv_d = wv_q;
    br_d = br_q;
    arv_d = arv_q;
    rr_d = rr_q;
    awa_d = awa_q;
    ara_d = ara_q;
    wd_d = wd_q;
    ws_d = ws_q;
    rd_d = rd_q;
    resp_d = resp_q;
    done_d = 1'b0;
    case (st_q)
      ENG_IDLE: begin
        if (cmd.start && cmd.write) begin
          awa_d = cmd.addr;
          wd_d = cmd.wdata;
          ws_d = cmd.strb;
          awv_d = 1'b1;
          wv_d = 1'b1;
          st_d = ENG_WR;
        end else if (cmd.start) begin
          ara_d = cmd.addr;
          arv_d = 1'b1;
          st_d = ENG_AR;
        end
      end
      ENG_WR: begin
        if (awv_q && i_awready) awv_d = 1'b0;
        if (wv_q && i_wready) wv_d = 1'b0;
        if (!awv_d && !wv_d) begin
          br_d = 1'b1;
          st_d = ENG_BR;
        end
      end
      ENG_BR: begin
        if (i_bvalid) begin
          resp_d = i_bresp;
          br_d = 1'b0;
          done_d = 1'b1;
          st_d = ENG_IDLE;
        end
      end
      ENG_AR: begin
        if (i_arready) begin
          arv_d = 1'b0;
          rr_d = 1'b1;
          st_d = ENG_RD;
        end
      end
      ENG_RD: begin
        if (i_rvalid) begin
          rd_d = i_rdata;
          resp_d = i_rresp;
          rr_d = 1'b0;
          done_d = 1'b1;
          st_d = ENG_IDLE;
        end
      end
      default: begin
        st_d = ENG_IDLE;
        awv_d = 1'b0;
        wv_d = 1'b0;
        br_d = 1'b0;
        arv_d = 1'b0;
        rr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ENG_IDLE;
      awv_q <= 1'b0;
      wv_q <= 1'b0;
      br_q <= 1'b0;
      arv_q <= 1'b0;
      rr_q <= 1'b0;
      awa_q <= '0;
      ara_q <= '0;
      wd_q <= RST_WORD;
      ws_q <= '0;
      rd_q <= RST_WORD;
      resp_q <= RESP_OKAY;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      awv_q <= awv_d;
      wv_q <= wv_d;
      br_q <= br_d;
      arv_q <= arv_d;
      rr_q <= rr_d;
      awa_q <= awa_d;
      ara_q <= ara_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      resp_q <= resp_d;
      done_q <= done_d;
    end
  end

  assign o_awaddr = awa_q;
  assign o_awvalid = awv_q;
  assign o_wdata = wd_q;
  assign o_wstrb = ws_q;
  assign o_wvalid = wv_q;
  assign o_bready = br_q;
  assign o_araddr = ara_q;
  assign o_arvalid = arv_q;
  assign o_rready = rr_q;
  assign cmd.busy = (st_q != ENG_IDLE);
  assign cmd.done = done_q;
  assign cmd.resp = resp_q;
  assign cmd.rdata = rd_q;
endmodule // sric_lite_master
`default_nettype wire

// ===== testbench/sric_host_chk.sv
// Checker: port-level properties of the stream request host
`timescale 1ns/10ps
`default_nettype none
module sric_host_chk
  import sric_pkg::*;
#(
  parameter int unsigned ALIGN_BITS = RQ_ALIGN_DEF
) (
  // Clock, reset and APB
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  // Register port
  input wire logic [LITE_AW-1:0] o_csr_awaddr,
  input wire logic [PROT_W-1:0] o_csr_awprot,
  input wire logic o_csr_awvalid,
  input wire logic i_csr_awready,
  input wire logic [31:0] o_csr_wdata,
  input wire logic [STRB_W-1:0] o_csr_wstrb,
  input wire logic o_csr_wvalid,
  input wire logic i_csr_wready,
  input wire logic [LITE_AW-1:0] o_csr_araddr,
  input wire logic [PROT_W-1:0] o_csr_arprot,
  input wire logic o_csr_arvalid,
  input wire logic i_csr_arready,
  // Request stream
  input wire logic [TDATA_W-1:0] o_rqst_tdata,
  input wire logic [TUSER_W-1:0] o_rqst_tuser,
  input wire logic o_rqst_tlast,
  input wire logic [TID_W-1:0] o_rqst_tid,
  input wire logic o_rqst_tvalid,
  input wire logic i_rqst_tready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic [31:0] low_mask;
  assign low_mask = (32'h1 << ALIGN_BITS) - 32'h1;
  prot_bits_zero_a: assert property (o_csr_awprot == 3'h0 && o_csr_arprot == 3'h0)
    else $error("protection bits not zero");
  aw_request_held_a: assert property (o_csr_awvalid && !i_csr_awready |=>
    o_csr_awvalid && $stable(o_csr_awaddr)) else $error("write address dropped early");
  w_data_held_a: assert property (o_csr_wvalid && !i_csr_wready |=>
    o_csr_wvalid && $stable(o_csr_wdata) && $stable(o_csr_wstrb)) else $error("write data moved");
  ar_request_held_a: assert property (o_csr_arvalid && !i_csr_arready |=>
    o_csr_arvalid && $stable(o_csr_araddr)) else $error("read address dropped early");
  beat_held_a: assert property (o_rqst_tvalid && !i_rqst_tready |=> o_rqst_tvalid &&
    $stable(o_rqst_tdata) && $stable(o_rqst_tuser) && $stable(o_rqst_tid))
    else $error("beat moved early");
  beat_single_a: assert property (o_rqst_tvalid && i_rqst_tready |=> !o_rqst_tvalid)
    else $error("beat not ended after acceptance");
  tlast_every_a: assert property (o_rqst_tvalid |-> o_rqst_tlast)
    else $error("tlast low on a beat");
  header_clean_a: assert property (o_rqst_tvalid |-> o_rqst_tuser[127:120] == 8'h00 &&
    o_rqst_tuser[39:36] == 4'h0 && (o_rqst_tuser[31:0] & low_mask) == 32'h0)
    else $error("header bits set");
  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("apb answer late");
  cover property (o_csr_awvalid && i_csr_awready);
  cover property (o_rqst_tvalid && !i_rqst_tready ##1 i_rqst_tready);
  cover property (o_csr_arvalid && !i_csr_arready ##1 i_csr_arready);
endmodule // sric_host_chk
bind sric_host sric_host_chk #(.ALIGN_BITS(ALIGN_BITS)) i_sric_host_chk (.i_clock, .i_rstn,
  .i_psel, .i_penable, .o_pready, .o_csr_awaddr, .o_csr_awprot, .o_csr_awvalid,
  .i_csr_awready, .o_csr_wdata, .o_csr_wstrb, .o_csr_wvalid, .i_csr_wready, .o_csr_araddr,
  .o_csr_arprot, .o_csr_arvalid, .i_csr_arready, .o_rqst_tdata, .o_rqst_tuser,
  .o_rqst_tlast, .o_rqst_tid, .o_rqst_tvalid, .i_rqst_tready);
`default_nettype wire

// ===== testbench/sric_dev_model.sv
// Device model: register-port slave and request stream sink
`timescale 1ns/10ps
`default_nettype none
module sric_dev_model
  import sric_pkg::*;
(
  // Clock, reset and pacing
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_stall,
  // Register port slave
  input wire logic [LITE_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [STRB_W-1:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [RESP_W-1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [LITE_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [RESP_W-1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Request stream sink and last accepted beat
  input wire logic [TDATA_W-1:0] i_tdata,
  input wire logic [TUSER_W-1:0] i_tuser,
  input wire logic [TID_W-1:0] i_tid,
  input wire logic i_tvalid,
  output logic o_tready,
  output logic [TDATA_W-1:0] o_beat_data,
  output logic [TUSER_W-1:0] o_beat_user,
  output logic [TID_W-1:0] o_beat_tid,
  output logic [7:0] o_beat_cnt
);
  logic [31:0] regs [4];
  logic go, got_aw, got_w;
  logic [LITE_AW-1:0] aw_q;
  logic [31:0] wd_q;
  logic [STRB_W-1:0] ws_q;
  // Slow mode opens the register-port ready lines only every other cycle; tready follows stall alone
  assign o_awready = i_awvalid && !got_aw && go;
  assign o_wready = i_wvalid && !got_w && go;
  assign o_arready = i_arvalid && !o_rvalid && go;
  // stall stands for a full buffer
  assign o_tready = !i_stall;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 4; i++) regs[i] <= 32'h0;
      {go, got_aw, got_w, o_bvalid, o_rvalid} <= 5'b10000;
      {aw_q, wd_q, ws_q, o_bresp, o_rresp, o_rdata} <= '0;
      {o_beat_data, o_beat_user, o_beat_tid, o_beat_cnt} <= '0;
    end else begin
      go <= i_slow ? !go : 1'b1;
      // address latched on handshake, protection unused
      if (o_awready) begin
        aw_q <= i_awaddr;
        got_aw <= 1'b1;
      end
      if (o_wready) begin
        wd_q <= i_wdata;
        ws_q <= i_wstrb;
        got_w <= 1'b1;
      end
      // lane writes, decode error off the map
      if (got_aw && got_w && !o_bvalid) begin
        for (int b = 0; b < 4; b++) begin
          if (ws_q[b] && aw_q[6:4] == 3'h0) regs[aw_q[3:2]][8*b +: 8] <= wd_q[8*b +: 8];
        end
        o_bresp <= (aw_q[6:4] == 3'h0) ? 2'h0 : 2'h3;
        o_bvalid <= 1'b1;
        got_aw <= 1'b0;
        got_w <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      // read word held until rready, then scrambled
      if (o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= (i_araddr[6:4] == 3'h0) ? 2'h0 : 2'h3;
        o_rdata <= regs[i_araddr[3:2]];
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_rdata <= ~o_rdata;
      end
      // beat and tid kept on valid and ready
      if (i_tvalid && o_tready) begin
        o_beat_data <= i_tdata;
        o_beat_user <= i_tuser;
        o_beat_tid <= i_tid;
        o_beat_cnt <= o_beat_cnt + 8'h01;
      end
    end
  end
endmodule // sric_dev_model
`default_nettype wire

// ===== testbench/sric_host_tb.sv
// Testbench: APB-driven register port and request stream of the host
`timescale 1ns/10ps
`default_nettype none
module sric_host_tb;
  import sric_pkg::*;
  localparam int unsigned ALIGN = 6;
  logic i_clock, i_rstn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, e, slow, stall;
  logic [APB_AW-1:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q, o_csr_wdata, i_csr_rdata;
  logic [LITE_AW-1:0] o_csr_awaddr, o_csr_araddr;
  logic [PROT_W-1:0] o_csr_awprot, o_csr_arprot;
  logic o_csr_awvalid, i_csr_awready, o_csr_wvalid, i_csr_wready, i_csr_bvalid, o_csr_bready;
  logic o_csr_arvalid, i_csr_arready, i_csr_rvalid, o_csr_rready, o_rqst_tlast, o_rqst_tvalid;
  logic i_rqst_tready;
  logic [STRB_W-1:0] o_csr_wstrb;
  logic [RESP_W-1:0] i_csr_bresp, i_csr_rresp;
  logic [TDATA_W-1:0] o_rqst_tdata, bd;
  logic [TUSER_W-1:0] o_rqst_tuser, bu;
  logic [TID_W-1:0] o_rqst_tid, bt;
  logic [7:0] bc;
  logic [31:0] mk [3];
  int err_count, comparisons;
  sric_host #(.ALIGN_BITS(ALIGN)) i_sric_host (.i_clock, .i_rstn, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_csr_awaddr,
    .o_csr_awprot, .o_csr_awvalid, .i_csr_awready, .o_csr_wdata, .o_csr_wstrb, .o_csr_wvalid,
    .i_csr_wready, .i_csr_bresp, .i_csr_bvalid, .o_csr_bready, .o_csr_araddr, .o_csr_arprot,
    .o_csr_arvalid, .i_csr_arready, .i_csr_rdata, .i_csr_rresp, .i_csr_rvalid, .o_csr_rready,
    .o_rqst_tdata, .o_rqst_tuser, .o_rqst_tlast, .o_rqst_tid, .o_rqst_tvalid, .i_rqst_tready);
  sric_dev_model i_sric_dev_model (.i_clock, .i_rstn, .i_slow(slow), .i_stall(stall),
    .i_awaddr(o_csr_awaddr), .i_awvalid(o_csr_awvalid), .o_awready(i_csr_awready),
    .i_wdata(o_csr_wdata), .i_wstrb(o_csr_wstrb), .i_wvalid(o_csr_wvalid),
    .o_wready(i_csr_wready), .o_bresp(i_csr_bresp), .o_bvalid(i_csr_bvalid),
    .i_bready(o_csr_bready), .i_araddr(o_csr_araddr), .i_arvalid(o_csr_arvalid),
    .o_arready(i_csr_arready), .o_rdata(i_csr_rdata), .o_rresp(i_csr_rresp),
    .o_rvalid(i_csr_rvalid), .i_rready(o_csr_rready), .i_tdata(o_rqst_tdata),
    .i_tuser(o_rqst_tuser), .i_tid(o_rqst_tid), .i_tvalid(o_rqst_tvalid),
    .o_tready(i_rqst_tready), .o_beat_data(bd), .o_beat_user(bu), .o_beat_tid(bt),
    .o_beat_cnt(bc));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // One APB transfer; waits for pready, never assumes its timing
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) err_count++;
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic lite(input logic [31:0] ctl);
    int n = 0;
    apb(1'b1, OFS_LITE_CTRL, ctl);
    do begin
      apb(1'b0, OFS_LITE_STAT, 32'h0);
      n++;
    end while (q[LSTAT_BUSY_BIT] !== 1'b0 && n < 100);
    if (q[LSTAT_BUSY_BIT] !== 1'b0) err_count++;
  endtask
  task automatic wait_beats(input logic [7:0] c);
    int n = 0;
    while (bc !== c && n < 100) begin
      @(posedge i_clock);
      n++;
    end
    if (bc !== c) err_count++;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  initial begin
    {i_rstn, i_psel, i_penable, i_pwrite, slow, stall, i_paddr, i_pwdata} <= '0;
    mk = '{32'h0123_4567, 32'h89ab_cdef, 32'hffff_5a5a};
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFS_LITE_ADDR, 32'h8);
    lite(32'h0);
    apb(1'b0, OFS_LITE_RDATA, 32'h0);
    chk(q, RST_WORD);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      apb(1'b1, OFS_LITE_ADDR, 32'h8 + 32'(4 * i));
      apb(1'b1, OFS_LITE_WDATA, i[0] ? 32'h1122_3344 : 32'ha1b2_c3d4);
      lite(i[0] ? 32'ha1 : 32'h51);
      chk({28'h0, q[3:0]}, 32'h2);
      lite(32'h0);
      apb(1'b0, OFS_LITE_RDATA, 32'h0);
      chk(q, i[0] ? 32'h1100_3300 : 32'h00b2_00d4);
    end
    apb(1'b1, OFS_LITE_ADDR, 32'h40);
    lite(32'hf1);
    chk({30'h0, q[3:2]}, 32'h3);
    lite(32'h0);
    chk({30'h0, q[3:2]}, 32'h3);
    $display("test register port done");
    stall <= 1'b1;
    for (int i = 0; i < 20; i++) apb(1'b1, OFS_RQ_DATA + 12'(4 * i), 32'h1000_0000 + 32'(i));
    for (int i = 0; i < 3; i++) apb(1'b1, OFS_RQ_MASK + 12'(4 * i), mk[i]);
    apb(1'b1, OFS_RQ_ADDR, 32'h1234_567f);
    apb(1'b1, OFS_RQ_CTRL, 32'h0000_000b);
    apb(1'b1, OFS_RQ_CTRL, 32'h0);
    apb(1'b0, OFS_RQ_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    chk({24'h0, bc}, 32'h0);
    stall <= 1'b0;
    wait_beats(8'h01);
    repeat (10) @(posedge i_clock);
    chk({24'h0, bc}, 32'h1);
    chk(bd[31:0], 32'h1000_0000);
    chk(bd[511:480], 32'h1000_000f);
    chk(bu[255:224], 32'h1000_0013);
    chk(bu[159:128], 32'h1000_0010);
    chk(bu[71:40], mk[0]);
    chk(bu[103:72], mk[1]);
    chk({16'h0, bu[119:104]}, 32'h5a5a);
    chk({20'h0, bu[127:120], bu[39:36]}, 32'h0);
    chk({28'h0, bu[35:32]}, 32'hd);
    chk(bu[31:0], 32'h1234_5640);
    chk({24'h0, bt}, 32'h0);
    apb(1'b1, OFS_RQ_CTRL, 32'h0);
    wait_beats(8'h02);
    chk({24'h0, bt}, 32'h1);
    chk({28'h0, bu[35:32]}, 32'h0);
    apb(1'b0, OFS_RQ_STAT, 32'h0);
    chk(q, 32'h0002_0100);
    $display("test request stream done");
    final_report();
  end
endmodule // sric_host_tb
`default_nettype wire
